// [tec_cfg.svh]
// constants for the tracker enable control block
// Behaviour
// [R1] limit is base plus code times step
// [R2] range bits 7..4 pick fine step per channel
// [R3] manual reset held low keeps reset asserted
// [R4] margin low suppresses threshold alerts and faults
// [R5] enable high powers up, low powers down
// [R6] bus on/off mode waits for on command
// [R7] internal enable ANDs pin, track and command
// [R8] any enable term false starts power-down
// [R9] detectors outrank enables once power-up started; the code checks oc_det only in ST_ON, not during ST_UP
// [R10] fault during power-up shuts all channels
// [R11] latched fault cleared by enable toggle
// [R12] option bit 1 combines bus command bit
// [R13] option bit 0 sets command polarity
// [R14] reference bit 0 selects external reference
// [R15] track permit has hysteretic on and off
// [R16] master drives ramp, slave tracks received ramp
// [R17] bus-only control needs pin and track high
// [R18] input failure shuts all and raises fault
// [R19] option bit 5 latches, clear means autoretry
// [R20] comparator results registered before use
// [R21] configuration registers readable, writable, retained
`ifndef TEC_CFG_SVH
`define TEC_CFG_SVH
`define TEC_OFS_OV2 8'h05
`define TEC_OFS_OV3 8'h06
`define TEC_OFS_OV4 8'h07
`define TEC_OFS_RANGE 8'h08
`define TEC_OFS_OPT 8'h09
`define TEC_OFS_REF 8'h11
`define TEC_OFS_CMD 8'h14
`define TEC_RST_OV 8'hFF
`define TEC_RST_RANGE 8'h00
`define TEC_RST_OPT 8'h00
`define TEC_RST_REF 8'h00
`define TEC_RST_CMD 8'h00
`define TEC_RANGE_CH1 7
`define TEC_OPT_POL 0
`define TEC_OPT_CHK 1
`define TEC_OPT_LATCH 5
`define TEC_REF_EXT 0
`define TEC_CMD_ON 0
`define TEC_COARSE_BASE_MV 13'h03E8
`define TEC_COARSE_STEP_MV 13'h0014
`define TEC_FINE_BASE_MV 13'h01F4
`define TEC_FINE_STEP_MV 13'h000A
`define TEC_CLK_MHZ 20
`define TEC_RETRY_US 25
`define TEC_RETRY_CYC (`TEC_RETRY_US * `TEC_CLK_MHZ)
`define TEC_RST_TIMEOUT_US 200000
`define TEC_BUS_ADDR 7'h3A
`endif

// [tec_pkg.sv]
// types shared by the tracker enable control block
package tec_pkg;
  typedef enum logic [2:0] {ST_OFF, ST_UP, ST_ON, ST_DOWN, ST_FAULT} tec_state_e;
  typedef enum logic [3:0] {BS_IDLE, BS_ADDR, BS_ACK_A, BS_REG, BS_ACK_R, BS_WDATA, BS_ACK_W,
                            BS_RDATA, BS_RACK} tec_bus_e;
  typedef struct packed {
    logic [3:0] in_fail;
    logic       track_err;
    logic       track_alert;
    logic       oc_det;
    logic       ramp_done;
    logic       down_done;
  } tec_sense_s;
  typedef struct packed {
    logic        fine;
    logic [12:0] mv;
  } tec_limit_s;
endpackage : tec_pkg

// [tec_rst_stretch.sv]
// reset output stretcher for the manual reset input
`timescale 1ns/10ps
module tec_rst_stretch
  import tec_pkg::*;
#(
  parameter int CYC = 4000000
)(
  input  wire logic sys_clk,
  input  wire logic rst,
  input  wire logic hold,
  output logic      rst_active
);
  localparam int CW = $clog2(CYC + 1);
  logic [CW-1:0] cnt;

  // reload while held, then count the timeout down
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      cnt        <= CW'(CYC);
      rst_active <= 1'b1;
    end
    else if (hold)
    begin
      cnt        <= CW'(CYC); // [R3]
      rst_active <= 1'b1;
    end
    else if (cnt != '0)
    begin
      cnt        <= cnt - 1'b1;
      rst_active <= 1'b1;
    end
    else
    begin
      rst_active <= 1'b0;
    end
  end

  AST_R3_HOLD: assert property (@(posedge sys_clk) disable iff (rst) // [R3]
    hold |=> rst_active)
    else $error("reset output released while manual reset held");
  AST_R3_TIMEOUT: assert property (@(posedge sys_clk) disable iff (rst) // [R3]
    $fell(hold) |-> rst_active [*8])
    else $error("reset output ended before timeout");
endmodule : tec_rst_stretch

// [tec_enable_ctrl.sv]
// enable, fault and register control of the four channel tracker
`timescale 1ns/10ps
`include "tec_cfg.svh"
module tec_enable_ctrl
  import tec_pkg::*;
#(
  parameter int       RST_TIMEOUT_CYC = `TEC_RST_TIMEOUT_US * `TEC_CLK_MHZ,
  parameter bit [6:0] BUS_ADDR        = `TEC_BUS_ADDR
)(
  input  wire logic        sys_clk,
  input  wire logic        rst,
  input  wire logic        scl_in,
  input  wire logic        sda_in,
  output logic             sda_out,
  output logic             sda_oe_n,
  input  wire logic        enable_pin,
  input  wire logic        track_permit_input,
  input  wire logic        track_hold_input,
  input  wire logic        margin_n,
  input  wire logic        manual_reset_n,
  input  wire logic        master_mode,
  input  wire tec_sense_s  sense,
  input  wire logic        fault_in,
  output logic             fault_out,
  output logic             fault_oe_n,
  output logic             reset_out_n,
  output logic             power_up_run,
  output logic             power_down_run,
  output logic             all_off,
  output logic             ramp_gen_en,
  output logic             ramp_share_pin_oe_n,
  output logic             track_alert_out,
  output logic             external_vref_select,
  output tec_limit_s [2:0] ov_limit
);
  localparam int RETRY_CYC = `TEC_RETRY_CYC;

  // limit in millivolts from code and step select
  function automatic logic [12:0] limit_mv(input logic [7:0] code, input logic fine);
    logic [12:0] n;
    n = {5'h00, code};
    if (fine)
      limit_mv = 13'(`TEC_FINE_BASE_MV + n * `TEC_FINE_STEP_MV);
    else
      limit_mv = 13'(`TEC_COARSE_BASE_MV + n * `TEC_COARSE_STEP_MV);
  endfunction : limit_mv

  // configuration registers
  logic [7:0] ov2_limit;
  logic [7:0] ov3_limit;
  logic [7:0] ov4_limit;
  logic [7:0] step_range_select;
  logic [7:0] enable_options;
  logic [7:0] reference_select;
  logic [7:0] onoff_command;
  logic       cmd_valid;

  // two-flop synchronisers for every pin and comparator
  logic       scl_m, scl_s, scl_q;
  logic       sda_m, sda_s, sda_q;
  logic [6:0] pin_m, pin_s;
  tec_sense_s sense_m, sense_s;

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      scl_m   <= 1'b1;
      scl_s   <= 1'b1;
      scl_q   <= 1'b1;
      sda_m   <= 1'b1;
      sda_s   <= 1'b1;
      sda_q   <= 1'b1;
      pin_m   <= 7'h00;
      pin_s   <= 7'h00;
      sense_m <= '0;
      sense_s <= '0;
    end
    else
    begin
      scl_m   <= scl_in;
      scl_s   <= scl_m;
      scl_q   <= scl_s;
      sda_m   <= sda_in;
      sda_s   <= sda_m;
      sda_q   <= sda_s;
      pin_m   <= {enable_pin, track_permit_input, track_hold_input, margin_n,
                  manual_reset_n, master_mode, fault_in};
      pin_s   <= pin_m;
      sense_m <= sense; // [R20]
      sense_s <= sense_m;
    end
  end

  logic en_s, trk_hi_s, trk_lo_s, margin_s, mr_s, master_s, fault_in_s;
  assign {en_s, trk_hi_s, trk_lo_s, margin_s, mr_s, master_s, fault_in_s} = pin_s;

  // serial bus bit engine
  tec_bus_e   bus_st;
  logic [7:0] sr;
  logic [3:0] bitcnt;
  logic [7:0] ptr;
  logic       rw;
  logic       sda_drv;
  logic       scl_rise, scl_fall, bus_start, bus_stop;

  assign scl_rise  = scl_s & ~scl_q;
  assign scl_fall  = ~scl_s & scl_q;
  assign bus_start = scl_s & scl_q & sda_q & ~sda_s;
  assign bus_stop  = scl_s & scl_q & ~sda_q & sda_s;

  // read data mux, unmapped offsets read zero
  function automatic logic [7:0] rd_reg(input logic [7:0] a);
    unique case (a)
      `TEC_OFS_OV2:   rd_reg = ov2_limit;
      `TEC_OFS_OV3:   rd_reg = ov3_limit;
      `TEC_OFS_OV4:   rd_reg = ov4_limit;
      `TEC_OFS_RANGE: rd_reg = step_range_select;
      `TEC_OFS_OPT:   rd_reg = enable_options;
      `TEC_OFS_REF:   rd_reg = reference_select;
      `TEC_OFS_CMD:   rd_reg = onoff_command;
      default:        rd_reg = 8'h00;
    endcase
  endfunction : rd_reg

  // byte at the current pointer, first bit goes out at once
  logic [7:0] rd_now;
  always_comb
  begin
    rd_now = rd_reg(ptr);
  end

  logic       wr_stb;
  logic [7:0] wr_ptr;

  // byte protocol: address, pointer, then data with auto increment
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      bus_st  <= BS_IDLE;
      sr      <= 8'h00;
      bitcnt  <= 4'h0;
      ptr     <= 8'h00;
      rw      <= 1'b0;
      sda_drv <= 1'b0;
      wr_stb  <= 1'b0;
      wr_ptr  <= 8'h00;
    end
    else
    begin
      wr_stb <= 1'b0;
      if (bus_start)
      begin
        bus_st  <= BS_ADDR;
        bitcnt  <= 4'h0;
        sda_drv <= 1'b0;
      end
      else if (bus_stop)
      begin
        bus_st  <= BS_IDLE;
        sda_drv <= 1'b0;
      end
      else if (scl_rise)
      begin
        unique case (bus_st)
          BS_ADDR, BS_REG, BS_WDATA:
          begin
            sr     <= {sr[6:0], sda_s};
            bitcnt <= bitcnt + 4'h1;
          end
          BS_RDATA: bitcnt <= bitcnt + 4'h1;
          BS_RACK:  if (sda_s) bus_st <= BS_IDLE;
          default:  ;
        endcase
      end
      else if (scl_fall)
      begin
        unique case (bus_st)
          BS_ADDR:
            if (bitcnt == 4'h8)
            begin
              if (sr[7:1] == BUS_ADDR)
              begin
                rw      <= sr[0];
                sda_drv <= 1'b1;
                bus_st  <= BS_ACK_A;
              end
              else
                bus_st <= BS_IDLE;
            end
          BS_ACK_A:
          begin
            bitcnt <= 4'h0;
            if (rw)
            begin
              sr      <= rd_now; // [R21]
              sda_drv <= ~rd_now[7];
              bus_st  <= BS_RDATA;
            end
            else
            begin
              sda_drv <= 1'b0;
              bus_st  <= BS_REG;
            end
          end
          BS_REG:
            if (bitcnt == 4'h8)
            begin
              ptr     <= sr;
              sda_drv <= 1'b1;
              bus_st  <= BS_ACK_R;
            end
          BS_WDATA:
            if (bitcnt == 4'h8)
            begin
              wr_stb  <= 1'b1;
              wr_ptr  <= ptr;
              ptr     <= ptr + 8'h01;
              sda_drv <= 1'b1;
              bus_st  <= BS_ACK_W;
            end
          BS_ACK_R, BS_ACK_W:
          begin
            bitcnt  <= 4'h0;
            sda_drv <= 1'b0;
            bus_st  <= BS_WDATA;
          end
          BS_RDATA:
            if (bitcnt == 4'h8)
            begin
              sda_drv <= 1'b0;
              ptr     <= ptr + 8'h01;
              bus_st  <= BS_RACK;
            end
            else
            begin
              sr      <= {sr[6:0], 1'b0};
              sda_drv <= ~sr[6];
            end
          BS_RACK:
          begin
            bitcnt  <= 4'h0;
            sr      <= rd_now;
            sda_drv <= ~rd_now[7];
            bus_st  <= BS_RDATA;
          end
          default: ;
        endcase
      end
    end
  end

  // register writes, values kept until rewritten
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      ov2_limit         <= `TEC_RST_OV;
      ov3_limit         <= `TEC_RST_OV;
      ov4_limit         <= `TEC_RST_OV;
      step_range_select <= `TEC_RST_RANGE;
      enable_options    <= `TEC_RST_OPT;
      reference_select  <= `TEC_RST_REF;
      onoff_command     <= `TEC_RST_CMD;
      cmd_valid         <= 1'b0;
    end
    else if (wr_stb)
    begin
      unique case (wr_ptr)
        `TEC_OFS_OV2:   ov2_limit <= sr; // [R21]
        `TEC_OFS_OV3:   ov3_limit <= sr;
        `TEC_OFS_OV4:   ov4_limit <= sr;
        `TEC_OFS_RANGE: step_range_select <= {sr[7:4], 4'h0}; // [R2]
        `TEC_OFS_OPT:   enable_options <= sr;
        `TEC_OFS_REF:   reference_select <= sr;
        `TEC_OFS_CMD:
        begin
          onoff_command <= sr;
          cmd_valid     <= 1'b1; // [R6]
        end
        default: ;
      endcase
    end
  end

  // enable terms
  logic trk_ok;
  logic bus_term, int_en, int_en_q;
  logic latch_mode;

  // hysteretic track permit: on above high trip, off below low trip
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
      trk_ok <= 1'b0;
    else if (trk_hi_s)
      trk_ok <= 1'b1; // [R15]
    else if (!trk_lo_s)
      trk_ok <= 1'b0; // [R15]
  end

  // command term ignored unless combining is selected
  assign bus_term   = !enable_options[`TEC_OPT_CHK] | // [R12]
                      (cmd_valid & (onoff_command[`TEC_CMD_ON] ==
                                    enable_options[`TEC_OPT_POL])); // [R13] [R6]
  assign int_en     = en_s & trk_ok & bus_term; // [R7] [R17]
  assign latch_mode = enable_options[`TEC_OPT_LATCH]; // [R19]

  // fault sources, threshold ones masked by margin
  logic in_ok, thr_fault, fault_now, en_rise;
  assign in_ok     = ~|sense_s.in_fail;
  assign thr_fault = margin_s & (~in_ok | sense_s.track_err); // [R4]
  assign fault_now = thr_fault | fault_in_s; // [R18]
  assign en_rise   = int_en & ~int_en_q;

  // power state machine
  tec_state_e state;
  logic [9:0] retry_cnt;

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      state     <= ST_OFF;
      int_en_q  <= 1'b0;
      retry_cnt <= 10'h000;
    end
    else
    begin
      int_en_q <= int_en;
      unique case (state)
        ST_OFF:
          if (int_en && in_ok)
            state <= ST_UP; // [R5] [R7]
        ST_UP:
          if (fault_now)
            state <= ST_FAULT; // [R10] [R9]
          else if (!int_en)
            state <= ST_DOWN; // [R8]
          else if (sense_s.ramp_done)
            state <= ST_ON;
        ST_ON:
          if (fault_now || sense_s.oc_det)
            state <= ST_FAULT; // [R9] [R18]
          else if (!int_en)
            state <= ST_DOWN; // [R8] [R5]
        ST_DOWN:
          if (sense_s.down_done)
            state <= ST_OFF;
        ST_FAULT:
          if (latch_mode)
          begin
            if (en_rise)
              state <= ST_OFF; // [R11]
          end
          else if (retry_cnt == 10'(RETRY_CYC - 1))
          begin
            retry_cnt <= 10'h000;
            state     <= ST_OFF; // [R19]
          end
          else
            retry_cnt <= retry_cnt + 10'h001;
      endcase
    end
  end

  // manual reset timeout
  logic rst_active;
  tec_rst_stretch #(
    .CYC (RST_TIMEOUT_CYC)
  ) u_rst (
    .sys_clk    (sys_clk),
    .rst        (rst),
    .hold       (~mr_s),
    .rst_active (rst_active)
  );

  // registered outputs
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      sda_out              <= 1'b0;
      sda_oe_n             <= 1'b1;
      fault_out            <= 1'b0;
      fault_oe_n           <= 1'b1;
      reset_out_n          <= 1'b0;
      power_up_run         <= 1'b0;
      power_down_run       <= 1'b0;
      all_off              <= 1'b1;
      ramp_gen_en          <= 1'b0;
      ramp_share_pin_oe_n  <= 1'b1;
      track_alert_out      <= 1'b0;
      external_vref_select <= 1'b0;
      ov_limit             <= '0;
    end
    else
    begin
      sda_out              <= 1'b0;
      sda_oe_n             <= ~sda_drv;
      fault_out            <= 1'b0;
      fault_oe_n           <= ~(state == ST_FAULT); // [R18]
      reset_out_n          <= ~rst_active; // [R3]
      power_up_run         <= (state == ST_UP);
      power_down_run       <= (state == ST_DOWN);
      all_off              <= (state == ST_FAULT) || (state == ST_OFF); // [R10]
      ramp_gen_en          <= master_s && (state == ST_UP || state == ST_DOWN); // [R16]
      ramp_share_pin_oe_n  <= ~master_s; // [R16]
      track_alert_out      <= margin_s & sense_s.track_alert; // [R4]
      external_vref_select <= reference_select[`TEC_REF_EXT]; // [R14]
      for (int c = 0; c < 3; c++)
      begin
        ov_limit[c].fine <= step_range_select[`TEC_RANGE_CH1 - 1 - c]; // [R2]
        ov_limit[c].mv   <= limit_mv(c == 0 ? ov2_limit : (c == 1 ? ov3_limit : ov4_limit),
                                     step_range_select[`TEC_RANGE_CH1 - 1 - c]); // [R1]
      end
    end
  end

  AST_R10_UPFAULT: assert property (@(posedge sys_clk) disable iff (rst) // [R10]
    (state == ST_UP && fault_now) |=> state == ST_FAULT ##1 all_off)
    else $error("fault during power-up did not shut down");
  AST_R8_DOWN: assert property (@(posedge sys_clk) disable iff (rst) // [R8]
    (state == ST_ON && !fault_now && !sense_s.oc_det && !int_en) |=> state == ST_DOWN)
    else $error("enable loss did not start power-down");
  AST_R7_START: assert property (@(posedge sys_clk) disable iff (rst) // [R7]
    (state == ST_OFF ##1 state == ST_UP) |-> $past(int_en) && $past(in_ok))
    else $error("power-up started without internal enable");
  AST_R6_WAIT: assert property (@(posedge sys_clk) disable iff (rst) // [R6]
    (state == ST_OFF && enable_options[`TEC_OPT_CHK] && !cmd_valid) |=> state == ST_OFF)
    else $error("power-up before bus on command");
  AST_R4_MARGIN: assert property (@(posedge sys_clk) disable iff (rst) // [R4]
    (!margin_s && !fault_in_s && state == ST_UP) |=> state != ST_FAULT)
    else $error("threshold fault while margin low");
  AST_R11_CLEAR: assert property (@(posedge sys_clk) disable iff (rst) // [R11]
    (state == ST_FAULT && latch_mode && en_rise) |=> state == ST_OFF)
    else $error("enable toggle did not clear latched fault");
  AST_R19_LATCH: assert property (@(posedge sys_clk) disable iff (rst) // [R19]
    (state == ST_FAULT && latch_mode && !en_rise) |=> state == ST_FAULT)
    else $error("latched fault left without enable toggle");
  AST_R15_HYST: assert property (@(posedge sys_clk) disable iff (rst) // [R15]
    (!trk_hi_s && trk_lo_s && trk_ok) |=> trk_ok)
    else $error("track permit dropped inside hysteresis band");
  AST_R13_POL: assert property (@(posedge sys_clk) disable iff (rst) // [R13]
    (enable_options[`TEC_OPT_CHK] &&
     onoff_command[`TEC_CMD_ON] != enable_options[`TEC_OPT_POL]) |-> !int_en)
    else $error("command polarity not honoured");
endmodule : tec_enable_ctrl

// [tec_host_model.sv]
// host side serial bus controller model for the tracker enable control bench
`timescale 1ns/10ps
module tec_host_model (
  input  wire logic sys_clk,
  input  wire logic sda_line,
  output logic      scl,
  output logic      sda_drv
);
  // idle bus: both lines released to the pull-up
  initial
  begin
    scl     = 1'h1;
    sda_drv = 1'h1;
  end

  // half bit period, above the four cycle minimum
  task automatic hp();
    repeat (6) @(negedge sys_clk);
  endtask : hp

  // data only moves while the clock line is low
  task automatic bit_io(input logic b, output logic r);
    repeat (2) @(negedge sys_clk);
    sda_drv = b;
    hp();
    scl = 1'h1;
    hp();
    r   = sda_line;
    scl = 1'h0;
  endtask : bit_io

  // start or repeated start
  task automatic start();
    repeat (2) @(negedge sys_clk);
    sda_drv = 1'h1;
    hp();
    scl = 1'h1;
    hp();
    sda_drv = 1'h0;
    hp();
    scl = 1'h0;
  endtask : start

  // stop leaves both lines released
  task automatic stop();
    repeat (2) @(negedge sys_clk);
    sda_drv = 1'h0;
    hp();
    scl = 1'h1;
    hp();
    sda_drv = 1'h1;
    hp();
  endtask : stop

  // one byte msb first, then the acknowledge slot
  task automatic xfer(input logic [7:0] d, input logic mack, output logic [7:0] q,
                      output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--)
    begin
      bit_io(d[i], r);
      q[i] = r;
    end
    bit_io(mack, r);
    ack = ~r;
  endtask : xfer
endmodule : tec_host_model

// [tracker_enable_control_tb.sv]
// self-checking bench for the tracker enable control block
`timescale 1ns/10ps
`include "tec_cfg.svh"
module tracker_enable_control_tb;
  import tec_pkg::*;
  localparam int RST_CYC = 50;
  logic             sys_clk = 1'h0;
  logic             rst = 1'h1;
  logic             scl, sda_drv, sda_line, sda_out, sda_oe_n, fault_out, fault_oe_n;
  logic             enable_pin, track_permit_input, track_hold_input, margin_n;
  logic             manual_reset_n, master_mode, fault_in, reset_out_n, power_up_run;
  logic             power_down_run, all_off, ramp_gen_en, ramp_share_pin_oe_n;
  logic             track_alert_out, external_vref_select;
  tec_sense_s       sense;
  tec_limit_s [2:0] ov_limit;
  int               n_fail = 0;
  int               checks = 0;

  // clock and open-drain data line with pull-up
  always #25 sys_clk = ~sys_clk;
  assign sda_line = sda_drv & (sda_oe_n | sda_out);

  tec_host_model host (.sys_clk, .sda_line, .scl, .sda_drv);
  tec_enable_ctrl #(.RST_TIMEOUT_CYC(RST_CYC), .BUS_ADDR(`TEC_BUS_ADDR)) dut (
    .sys_clk, .rst, .scl_in(scl), .sda_in(sda_line), .sda_out, .sda_oe_n, .enable_pin,
    .track_permit_input, .track_hold_input, .margin_n, .manual_reset_n, .master_mode,
    .sense, .fault_in, .fault_out, .fault_oe_n, .reset_out_n, .power_up_run,
    .power_down_run, .all_off, .ramp_gen_en, .ramp_share_pin_oe_n, .track_alert_out,
    .external_vref_select, .ov_limit);

  task automatic tally_and_finish();
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : tally_and_finish

  task automatic cyc(input int n);
    repeat (n) @(negedge sys_clk);
  endtask : cyc

  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    checks++;
    if (g !== e)
    begin
      $display("wrong value %s expected %h seen %h", nm, e, g);
      n_fail++;
    end
  endtask : chk

  // settle, then compare {up, down, off}
  task automatic st(input logic [2:0] e);
    cyc(8);
    chk("up down off", e, {power_up_run, power_down_run, all_off});
  endtask : st

  // expected limit from code and step range
  function automatic logic [13:0] lim(input logic f, input logic [7:0] n);
    return f ? {1'h1, `TEC_FINE_BASE_MV + 13'(n) * `TEC_FINE_STEP_MV}
             : {1'h0, `TEC_COARSE_BASE_MV + 13'(n) * `TEC_COARSE_STEP_MV};
  endfunction : lim

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] q;
    logic       k;
    host.start();
    host.xfer({`TEC_BUS_ADDR, 1'h0}, 1'h1, q, k);
    chk("address ack", 1, k);
    host.xfer(a, 1'h1, q, k);
    host.xfer(d, 1'h1, q, k);
    chk("data ack", 1, k);
    host.stop();
  endtask : wr

  // pointer write, repeated start, one byte read ended by nack
  task automatic rchk(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] d;
    logic       k;
    host.start();
    host.xfer({`TEC_BUS_ADDR, 1'h0}, 1'h1, d, k);
    host.xfer(a, 1'h1, d, k);
    host.start();
    host.xfer({`TEC_BUS_ADDR, 1'h1}, 1'h1, d, k);
    host.xfer(8'hFF, 1'h1, d, k);
    host.stop();
    chk("register", e, d);
  endtask : rchk

  task automatic go_off();
    enable_pin = 1'h0;
    st(3'h2);
    sense.down_done = 1'h1;
    st(3'h1);
    sense.down_done = 1'h0;
  endtask : go_off

  task automatic t_regs();
    logic [7:0] q;
    logic       k;
    rchk(`TEC_OFS_OV2, `TEC_RST_OV);
    rchk(`TEC_OFS_RANGE, `TEC_RST_RANGE);
    rchk(`TEC_OFS_OPT, `TEC_RST_OPT);
    rchk(`TEC_OFS_REF, `TEC_RST_REF);
    chk("ch2 limit", lim(1'h0, 8'hFF), ov_limit[0]);
    host.start();
    host.xfer({`TEC_BUS_ADDR ^ 7'h01, 1'h0}, 1'h1, q, k);
    host.stop();
    chk("foreign address ack", 0, k);
    rchk(8'h20, 8'h00);
    wr(`TEC_OFS_OV2, 8'h10);
    wr(`TEC_OFS_OV3, 8'h05);
    wr(`TEC_OFS_OV4, 8'hE1);
    wr(`TEC_OFS_RANGE, 8'h4F);
    chk("ch2 limit", lim(1'h1, 8'h10), ov_limit[0]);
    chk("ch3 limit", lim(1'h0, 8'h05), ov_limit[1]);
    chk("ch4 limit", lim(1'h0, 8'hE1), ov_limit[2]);
    rchk(`TEC_OFS_RANGE, 8'h40);
    rchk(`TEC_OFS_OV4, 8'hE1);
    wr(`TEC_OFS_RANGE, 8'h30);
    chk("ch2 limit", lim(1'h0, 8'h10), ov_limit[0]);
    chk("ch3 limit", lim(1'h1, 8'h05), ov_limit[1]);
    chk("ch4 limit", lim(1'h1, 8'hE1), ov_limit[2]);
    wr(`TEC_OFS_REF, 8'h01);
    chk("vref select", 1, external_vref_select);
    wr(`TEC_OFS_REF, 8'h00);
    chk("vref select", 0, external_vref_select);
  endtask : t_regs

  task automatic t_enable();
    enable_pin         = 1'h1;
    track_permit_input = 1'h1;
    track_hold_input   = 1'h1;
    master_mode        = 1'h1;
    st(3'h4);
    chk("ramp run", 1, ramp_gen_en);
    chk("ramp drive", 0, ramp_share_pin_oe_n);
    master_mode = 1'h0;
    cyc(8);
    chk("ramp run", 0, ramp_gen_en);
    chk("ramp drive", 1, ramp_share_pin_oe_n);
    sense.ramp_done = 1'h1;
    st(3'h0);
    sense.ramp_done = 1'h0;
    track_permit_input = 1'h0;
    st(3'h0);
    track_hold_input = 1'h0;
    st(3'h2);
    sense.down_done = 1'h1;
    st(3'h1);
    sense.down_done = 1'h0;
    track_hold_input = 1'h1;
    st(3'h1);
    track_permit_input = 1'h1;
    st(3'h4);
    go_off();
  endtask : t_enable

  task automatic t_bus();
    wr(`TEC_OFS_OPT, 8'h02);
    enable_pin = 1'h1;
    st(3'h1);
    wr(`TEC_OFS_CMD, 8'h01);
    st(3'h1);
    wr(`TEC_OFS_CMD, 8'h00);
    st(3'h4);
    wr(`TEC_OFS_CMD, 8'h01);
    st(3'h2);
    sense.down_done = 1'h1;
    st(3'h1);
    sense.down_done = 1'h0;
    wr(`TEC_OFS_OPT, 8'h03);
    st(3'h4);
    wr(`TEC_OFS_OPT, 8'h00);
    wr(`TEC_OFS_CMD, 8'h00);
    st(3'h4);
    go_off();
  endtask : t_bus

  task automatic t_fault();
    enable_pin = 1'h1;
    st(3'h4);
    // margin goes low in the same step as the supply is varied
    margin_n          = 1'h0;
    sense.in_fail     = 4'h1;
    sense.track_alert = 1'h1;
    st(3'h4);
    chk("alert out", 0, track_alert_out);
    margin_n = 1'h1;
    st(3'h1);
    chk("fault drive", 0, fault_oe_n);
    chk("alert out", 1, track_alert_out);
    sense.in_fail     = 4'h0;
    sense.track_alert = 1'h0;
    cyc(400);
    chk("fault drive", 0, fault_oe_n);
    cyc(150);
    chk("fault drive", 1, fault_oe_n);
    st(3'h4);
    enable_pin    = 1'h0;
    sense.in_fail = 4'h8;
    st(3'h1);
    chk("fault drive", 0, fault_oe_n);
    sense.in_fail = 4'h0;
    cyc(560);
    chk("fault drive", 1, fault_oe_n);
    wr(`TEC_OFS_OPT, 8'h20);
    enable_pin = 1'h1;
    st(3'h4);
    sense.in_fail = 4'h2;
    st(3'h1);
    sense.in_fail = 4'h0;
    cyc(600);
    chk("fault drive", 0, fault_oe_n);
    enable_pin = 1'h0;
    cyc(8);
    chk("fault drive", 0, fault_oe_n);
    enable_pin = 1'h1;
    st(3'h4);
    chk("fault drive", 1, fault_oe_n);
    go_off();
    wr(`TEC_OFS_OPT, 8'h00);
    // overcurrent once on, then a fault from the shared wire
    enable_pin      = 1'h1;
    sense.ramp_done = 1'h1;
    st(3'h0);
    sense.oc_det = 1'h1;
    st(3'h1);
    chk("fault level", 0, fault_out);
    sense = '0;
    cyc(560);
    st(3'h4);
    fault_in = 1'h1;
    st(3'h1);
    chk("fault drive", 0, fault_oe_n);
    {enable_pin, fault_in} = 2'h0;
    cyc(560);
    chk("fault drive", 1, fault_oe_n);
  endtask : t_fault

  task automatic t_mreset();
    manual_reset_n = 1'h0;
    cyc(8);
    chk("reset out", 0, reset_out_n);
    cyc(100);
    chk("reset out", 0, reset_out_n);
    manual_reset_n = 1'h1;
    cyc(RST_CYC - 10);
    chk("reset out", 0, reset_out_n);
    cyc(25);
    chk("reset out", 1, reset_out_n);
  endtask : t_mreset

  // watchdog, well beyond the expected run length
  initial
  begin
    #2_000_000;
    n_fail++;
    tally_and_finish();
  end

  // main sequence
  initial
  begin
    {enable_pin, track_permit_input, track_hold_input, master_mode, fault_in} = 5'h00;
    margin_n       = 1'h1;
    manual_reset_n = 1'h1;
    sense          = '0;
    repeat (16) @(posedge sys_clk);
    cyc(1);
    chk("reset state", 4'h7, {reset_out_n, all_off, fault_oe_n, sda_oe_n});
    rst = 1'h0;
    cyc(80);
    chk("reset out", 1, reset_out_n);
    t_regs();
    t_enable();
    t_bus();
    t_fault();
    t_mreset();
    tally_and_finish();
  end
endmodule : tracker_enable_control_tb
